// ===== dv/hbcfg_host.sv
// host controller model driving the serial register port
`timescale 1ns/10ps
module hbcfg_host (
	input wire logic i_core_clk,
	input wire logic i_sdo,
	output logic o_sclk,
	output logic o_ncs,
	output logic o_sdi
);
	initial begin
		o_sclk = 1'b0;
		o_ncs = 1'b1;
		o_sdi = 1'b0;
	end
	// one whole frame, msb first, shift on rise, sample on fall
	task xfer(input logic [15:0] f, output logic [7:0] rd);
		integer i;
		rd = 8'h00;
		@(posedge i_core_clk);
		#2 o_ncs = 1'b0;
		for (i = 15; i >= 0; i--) begin
			repeat (10) @(posedge i_core_clk);
			#2 o_sclk = 1'b1;
			o_sdi = f[i];
			repeat (10) @(posedge i_core_clk);
			#2 o_sclk = 1'b0;
			if (i < 8) begin
				rd[i] = i_sdo;
			end
		end
		repeat (10) @(posedge i_core_clk);
		#2 o_ncs = 1'b1;
		// released data line must not look held
		o_sdi = ~o_sdi;
		repeat (8) @(posedge i_core_clk);
		// hand back off the clock edge
		#2;
	endtask : xfer
endmodule : hbcfg_host

// ===== dv/hbcfg_top_sva.sv
// port assertions for the configuration register block
`timescale 1ns/10ps
module hbcfg_top_chk #(
	parameter logic [2:0] SLEW_CAP_CODE = 3'h3
) (
	input logic i_core_clk,
	input logic i_sys_rst,
	input logic i_ncs,
	input logic o_sdo_oe,
	input logic i_enable_input_one_pin,
	input logic i_recirculating,
	input logic i_output_slewing,
	input logic i_blanking,
	input logic o_pwm_extend,
	input logic [1:0] o_load_type_select,
	input logic [2:0] o_current_trip_level_select,
	input logic [1:0] o_regulation_off_time,
	input logic [10:0] o_off_time_cycles,
	input logic [2:0] o_output_slew_select,
	input logic [2:0] o_rise_slew_select,
	input logic o_rise_slew_capped,
	input logic [1:0] o_bridge_mode,
	input logic [1:0] o_overcurrent_filter_select,
	input logic [7:0] o_filter_cycles,
	input logic [1:0] o_overcurrent_threshold_select,
	input logic [6:0] o_threshold_pct,
	input logic o_pin_reg_unlocked,
	input logic o_input_one,
	input logic o_current_report_en
);
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (i_sys_rst);
	wire busy = i_recirculating | i_output_slewing | i_blanking;
	wire low_side = o_bridge_mode == 2'h2 && o_load_type_select == 2'h1;
	wire [1:0] fs = o_overcurrent_filter_select;
	wire [1:0] ts = o_overcurrent_threshold_select;
	wire [7:0] f_exp = fs == 2'h0 ? 8'hf0 : fs == 2'h1 ? 8'h78 : fs == 2'h2 ? 8'h3c : 8'h08;
	wire [6:0] t_exp = ts == 2'h0 ? 7'h64 : ts == 2'h2 ? 7'h4b : 7'h32;
	wire [17:0] cfg = {o_pwm_extend, o_load_type_select, o_current_trip_level_select,
		o_regulation_off_time, o_output_slew_select, o_bridge_mode, fs, ts};
	wire [10:0] off_exp = 11'h320 + 11'h190 * o_regulation_off_time;
	wire cap_exp = low_side && o_output_slew_select > SLEW_CAP_CODE;
	wire [2:0] rise_exp = cap_exp ? SLEW_CAP_CODE : o_output_slew_select;
	a_off_time_map: assert property (o_off_time_cycles == off_exp)
		else $error("off time count wrong");
	a_sdo_oe_track: assert property (o_sdo_oe == !$past(i_ncs, 2))
		else $error("sdo enable wrong");
	a_filter_map: assert property (o_filter_cycles == f_exp)
		else $error("filter count wrong");
	a_thr_map: assert property (o_threshold_pct == t_exp)
		else $error("threshold wrong");
	a_slew_cap_flag: assert property (o_rise_slew_capped == cap_exp)
		else $error("slew cap flag wrong");
	a_rise_slew_val: assert property (o_rise_slew_select == rise_exp)
		else $error("rise slew wrong");
	a_report_gated: assert property (low_side && busy |=> !o_current_report_en)
		else $error("report not gated");
	a_report_free: assert property (!busy |=> o_current_report_en)
		else $error("report wrongly off");
	a_cfg_quiet: assert property (i_ncs [*8] |=> $stable(cfg))
		else $error("config moved without frame");
	a_pin_pass: assert property ((!o_pin_reg_unlocked && $stable(i_enable_input_one_pin)) [*4]
		|-> o_input_one == i_enable_input_one_pin)
		else $error("locked pin not passed");
endmodule : hbcfg_top_chk
bind hbcfg_top hbcfg_top_chk #(.SLEW_CAP_CODE(SLEW_CAP_CODE)) i_chk (.i_core_clk, .i_sys_rst,
	.i_ncs, .i_enable_input_one_pin, .i_recirculating, .i_output_slewing, .i_blanking,
	.o_pwm_extend, .o_load_type_select, .o_current_trip_level_select, .o_regulation_off_time,
	.o_off_time_cycles, .o_output_slew_select, .o_rise_slew_select, .o_rise_slew_capped,
	.o_bridge_mode, .o_overcurrent_filter_select, .o_filter_cycles,
	.o_overcurrent_threshold_select, .o_threshold_pct, .o_pin_reg_unlocked, .o_input_one,
	.o_current_report_en, .o_sdo_oe);

// ===== dv/hbcfg_top_test.sv
// self-checking bench for the configuration register block
`timescale 1ns/10ps
module hbcfg_top_test;
	logic i_core_clk = 1'b0;
	logic i_sys_rst = 1'b1;
	logic sclk, ncs, sdi, sdo, pe, rc, cl, so, i1, i2, re;
	logic [2:0] pins = 3'h0;
	logic [2:0] lvl = 3'h0;
	logic [1:0] lt, md, hb;
	logic [2:0] tl, ss, rs;
	logic [10:0] oc;
	logic [7:0] fc, rd;
	logic [6:0] tp;
	integer errors = 0;
	integer compares = 0;
	integer k;
	logic [10:0] oct [4] = '{11'h320, 11'h4b0, 11'h640, 11'h7d0};
	logic [7:0] fct [4] = '{8'hf0, 8'h78, 8'h3c, 8'h08};
	logic [6:0] tpt [4] = '{7'h64, 7'h32, 7'h4b, 7'h32};
	// combine select, register bits, pins {shutoff,in1,in2}, expected
	logic [21:0] pct [7] = '{{8'h00, 8'h00, 3'h7, 3'h7}, {8'h00, 8'h0b, 3'h0, 3'h7},
		{8'h00, 8'h00, 3'h0, 3'h0}, {8'h07, 8'h0b, 3'h0, 3'h0}, {8'h07, 8'h00, 3'h7, 3'h0},
		{8'h07, 8'h0b, 3'h7, 3'h7}, {8'h05, 8'h02, 3'h1, 3'h2}};
	always #12.5 i_core_clk = ~i_core_clk;
	hbcfg_host i_host (.i_core_clk(i_core_clk), .i_sdo(sdo), .o_sclk(sclk), .o_ncs(ncs),
		.o_sdi(sdi));
	hbcfg_top i_dut (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .i_sclk(sclk),
		.i_ncs(ncs), .i_sdi(sdi), .o_sdo(sdo), .o_sdo_oe(), .i_bridge_shutoff_pin(pins[2]),
		.i_enable_input_one_pin(pins[1]), .i_phase_input_two_pin(pins[0]),
		.i_recirculating(lvl[2]), .i_output_slewing(lvl[1]), .i_blanking(lvl[0]),
		.o_pwm_extend(pe), .o_load_type_select(lt), .o_current_trip_level_select(tl),
		.o_regulation_off_time(), .o_off_time_cycles(oc), .o_output_slew_select(ss),
		.o_rise_slew_select(rs), .o_rise_slew_capped(rc), .o_bridge_mode(md),
		.o_overcurrent_filter_select(), .o_filter_cycles(fc),
		.o_overcurrent_threshold_select(), .o_threshold_pct(tp), .o_config_locked(cl),
		.o_pin_reg_unlocked(), .o_shutoff(so), .o_input_one(i1), .o_input_two(i2),
		.o_half_bridge_off(hb), .o_current_report_en(re));
	task chk(input logic [10:0] seen, input logic [10:0] exp);
		compares++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task wr(input logic [5:0] a, input logic [7:0] d);
		i_host.xfer({2'h0, a, d}, rd);
	endtask : wr
	task rchk(input logic [5:0] a, input logic [7:0] e);
		i_host.xfer({2'h1, a, 8'h00}, rd);
		chk({3'h0, rd}, {3'h0, e});
	endtask : rchk
	task test_done;
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : test_done
	initial begin
		#1000000;
		errors++;
		test_done();
	end
	initial begin
		repeat (5) @(posedge i_core_clk);
		#2 i_sys_rst = 1'b0;
		rchk(6'h0b, 8'h00);
		rchk(6'h0c, 8'h40);
		rchk(6'h0d, 8'h04);
		rchk(6'h09, 8'h0c);
		chk(oc, 11'h4b0);
		wr(6'h0b, 8'hff);
		wr(6'h0c, 8'hff);
		wr(6'h0d, 8'hff);
		rchk(6'h0b, 8'he7);
		rchk(6'h0c, 8'hdf);
		rchk(6'h0d, 8'hdf);
		chk({5'h0, pe, lt, tl}, 11'h03f);
		chk({6'h0, ss, md}, 11'h01f);
		wr(6'h0a, 8'hff);
		rchk(6'h0a, 8'h00);
		for (k = 0; k < 4; k++) begin
			wr(6'h0c, 8'(k << 6));
			wr(6'h0d, 8'(k * 72));
			chk(oc, oct[k]);
			chk({3'h0, fc}, {3'h0, fct[k]});
			chk({4'h0, tp}, {4'h0, tpt[k]});
		end
		wr(6'h08, 8'h0a);
		chk({10'h0, cl}, 11'h001);
		wr(6'h0b, 8'h55);
		rchk(6'h0b, 8'he7);
		wr(6'h08, 8'h09);
		wr(6'h0b, 8'h55);
		rchk(6'h0b, 8'h45);
		pins = 3'h7;
		repeat (5) @(posedge i_core_clk);
		#2 chk({8'h0, so, i1, i2}, 11'h007);
		wr(6'h08, 8'h11);
		for (k = 0; k < 7; k++) begin
			wr(6'h0d, pct[k][21:14]);
			wr(6'h09, pct[k][13:6]);
			pins = pct[k][5:3];
			repeat (5) @(posedge i_core_clk);
			chk({8'h0, so, i1, i2}, {8'h0, pct[k][2:0]});
		end
		wr(6'h0d, 8'h00);
		wr(6'h09, 8'h04);
		pins = 3'h0;
		wr(6'h0b, 8'h20);
		wr(6'h0c, 8'h5e);
		chk({7'h0, rc, rs}, 11'h00b);
		repeat (5) @(posedge i_core_clk);
		chk({9'h0, hb}, 11'h002);
		for (k = 0; k < 3; k++) begin
			@(posedge i_core_clk);
			#2 lvl = 3'(1 << k);
			repeat (2) @(posedge i_core_clk);
			#2 chk({10'h0, re}, 11'h000);
			lvl = 3'h0;
			repeat (2) @(posedge i_core_clk);
			#2 chk({10'h0, re}, 11'h001);
		end
		wr(6'h0c, 8'h4a);
		chk({7'h0, rc, rs}, 11'h002);
		test_done();
	end
endmodule : hbcfg_top_test

// ===== hw/hbcfg_frame_if.sv
// decoded serial frame between the shifter and the register file
`timescale 1ns/10ps
interface hbcfg_frame_if;
	logic frame_done;
	logic is_read;
	logic [5:0] addr;
	logic [7:0] wdata;
	logic hdr_valid;
	logic [7:0] rdata;

	modport shifter (
		output frame_done,
		output is_read,
		output addr,
		output wdata,
		output hdr_valid,
		input rdata
	);

	modport regfile (
		input frame_done,
		input is_read,
		input addr,
		input wdata,
		input hdr_valid,
		output rdata
	);
endinterface : hbcfg_frame_if

// ===== hw/hbcfg_pin_combine.sv
// combines synchronised control pins with their register bits
`timescale 1ns/10ps
module hbcfg_pin_combine (
	input wire logic i_core_clk,
	input wire logic i_sys_rst,
	input wire logic [2:0] i_pin,
	input wire logic [2:0] i_reg_bit,
	input wire logic [2:0] i_and_sel,
	input wire logic i_unlocked,
	output logic [2:0] o_comb
);
	logic [2:0] comb_q;
	logic [2:0] comb_d;

	function automatic logic combine(input logic pin, input logic rb, input logic sel,
			input logic unl);
		combine = !unl ? pin : (sel ? (pin & rb) : (pin | rb));
	endfunction : combine

	assign comb_d[2] = combine(i_pin[2], i_reg_bit[2], i_and_sel[2], i_unlocked);
	assign comb_d[1] = combine(i_pin[1], i_reg_bit[1], i_and_sel[1], i_unlocked);
	assign comb_d[0] = combine(i_pin[0], i_reg_bit[0], i_and_sel[0], i_unlocked);

	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			comb_q <= 3'h0;
		end else begin
			comb_q <= comb_d;
		end
	end

	assign o_comb = comb_q;
endmodule : hbcfg_pin_combine

// ===== hw/hbcfg_pkg.sv
// types shared by the configuration register block
package hbcfg_pkg;
	typedef enum logic [1:0] {
		HBCFG_MODE_PH_EN,
		HBCFG_MODE_PWM,
		HBCFG_MODE_INDEP
	} hbcfg_mode_t;

	typedef enum logic [1:0] {
		HBCFG_SPI_IDLE,
		HBCFG_SPI_HEADER,
		HBCFG_SPI_DATA
	} hbcfg_spi_state_t;
endpackage : hbcfg_pkg

// ===== hw/hbcfg_regs.svh
// register offsets, field positions, reset values and timing counts
// Summary of operation
// - second configuration register at 0Bh, reset value 00h.
// - bit 7 of it enables extra coast states in PWM mode.
// - bits 6-5 of it hold the two-bit load type.
// - bits 2-0 of it hold the current trip level.
// - third configuration register at 0Ch, reset 40h, off-time code 01.
// - its bits 7-6 give off time 20, 30, 40 or 50 us.
// - its bits 4-2 hold the output slew selection.
// - its bits 1-0 select full-bridge or independent half-bridge modes.
// - fourth configuration register at 0Dh, reset 04h, shutoff combine AND.
// - its bits 7-6 pick overcurrent filter 6, 3, 1.5 or 0.2 us.
// - its bits 4-3 pick threshold 100, 50, 75 or 50 percent.
// - bit 2 combines shutoff pin and bit: 0 OR, 1 AND, when unlocked.
// - bit 1 combines input-one pin and bit: 0 OR, 1 AND, when unlocked.
// - bit 0 combines input-two pin and bit: 0 OR, 1 AND, when unlocked.
// - independent low-side: no current report during recirculation, slewing or blanking.
// - independent half-bridge coast control exists only in serial variants.
// - independent low-side: rising slew capped at 8 V/us setting.
// - register shutoff bit combines with pin when unlocked, resets to one.
// - register input-one bit combines with pin when unlocked, resets to zero.
// - lock code 10b blocks configuration writes; other codes unlock; unlocked at reset.
`ifndef HBCFG_REGS_SVH
`define HBCFG_REGS_SVH

`define HBCFG_ADDR_CMD 6'h08
`define HBCFG_ADDR_PIN 6'h09
`define HBCFG_ADDR_CFG2 6'h0b
`define HBCFG_ADDR_CFG3 6'h0c
`define HBCFG_ADDR_CFG4 6'h0d

`define HBCFG_RST_CMD 8'h09
`define HBCFG_RST_PIN 8'h0c
`define HBCFG_RST_CFG2 8'h00
`define HBCFG_RST_CFG3 8'h40
`define HBCFG_RST_CFG4 8'h04

`define HBCFG_MASK_CMD 8'h1b
`define HBCFG_MASK_PIN 8'h0f
`define HBCFG_MASK_CFG2 8'he7
`define HBCFG_MASK_CFG3 8'hdf
`define HBCFG_MASK_CFG4 8'hdf

`define HBCFG_LOCK_CODE 2'h2
`define HBCFG_CMD_REGLOCK_LO 0
`define HBCFG_CMD_PINLOCK_LO 3
`define HBCFG_PIN_SHUTOFF 3
`define HBCFG_PIN_SHUTOFF2 2
`define HBCFG_PIN_IN1 1
`define HBCFG_PIN_IN2 0

`define HBCFG_C2_EXTEND 7
`define HBCFG_C2_LOAD_LO 5
`define HBCFG_C2_TRIP_LO 0
`define HBCFG_C3_REGULATION_OFF_TIME_LO 6
`define HBCFG_C3_SLEW_LO 2
`define HBCFG_C3_MODE_LO 0
`define HBCFG_C4_FILT_LO 6
`define HBCFG_C4_THR_LO 3
`define HBCFG_C4_SEL_SHUTOFF 2
`define HBCFG_C4_SEL_IN1 1
`define HBCFG_C4_SEL_IN2 0

`define HBCFG_LOAD_LOW_SIDE 2'h1

`define HBCFG_CLK_MHZ 40
`define HBCFG_REGULATION_OFF_TIME_00_US 20
`define HBCFG_REGULATION_OFF_TIME_01_US 30
`define HBCFG_REGULATION_OFF_TIME_10_US 40
`define HBCFG_REGULATION_OFF_TIME_11_US 50
`define HBCFG_FILT_00_NS 6000
`define HBCFG_FILT_01_NS 3000
`define HBCFG_FILT_10_NS 1500
`define HBCFG_FILT_11_NS 200

`define HBCFG_THR_FULL_PCT 7'h64
`define HBCFG_THR_3Q_PCT 7'h4b
`define HBCFG_THR_HALF_PCT 7'h32

`define HBCFG_FRAME_BITS 5'h10
`define HBCFG_HDR_BITS 5'h08

`endif

// ===== hw/hbcfg_spi_shift.sv
// serial register port: pin synchronisers, frame shifter, read-back
`timescale 1ns/10ps
`include "hbcfg_regs.svh"
module hbcfg_spi_shift
	import hbcfg_pkg::*;
(
	input wire logic i_core_clk,
	input wire logic i_sys_rst,
	input wire logic i_sclk,
	input wire logic i_ncs,
	input wire logic i_sdi,
	output logic o_sdo,
	output logic o_sdo_oe,
	hbcfg_frame_if.shifter frm
);
	logic [2:0] sclk_q;
	logic [2:0] ncs_q;
	logic [1:0] sdi_q;
	logic [4:0] cnt_q;
	logic [7:0] rx_q;
	logic [7:0] hdr_q;
	logic [7:0] tx_q;
	logic sdo_q;
	logic load_q;
	logic done_q;
	hbcfg_spi_state_t state_q;
	wire sclk_fall = sclk_q[2] & ~sclk_q[1];
	wire sclk_rise = ~sclk_q[2] & sclk_q[1];
	wire ncs_high = ncs_q[1];
	// frame state is kept one cycle past the ncs rise, so the pulse sees it
	wire ncs_idle = ncs_q[1] & ncs_q[2];
	wire ncs_rise = ncs_q[1] & ~ncs_q[2];
	wire hdr_last = sclk_fall & (cnt_q == `HBCFG_HDR_BITS - 5'h01);

	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			sclk_q <= 3'h0;
			ncs_q <= 3'h7;
			sdi_q <= 2'h0;
		end else begin
			sclk_q <= {sclk_q[1:0], i_sclk};
			ncs_q <= {ncs_q[1:0], i_ncs};
			sdi_q <= {sdi_q[0], i_sdi};
		end
	end

	// sample on falling sclk, launch on rising sclk
	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst || ncs_idle) begin
			cnt_q <= 5'h00;
			rx_q <= 8'h00;
			state_q <= HBCFG_SPI_IDLE;
		end else if (sclk_fall && cnt_q != 5'h1f) begin
			cnt_q <= cnt_q + 5'h01;
			rx_q <= {rx_q[6:0], sdi_q[1]};
			state_q <= (cnt_q >= `HBCFG_HDR_BITS - 5'h01) ? HBCFG_SPI_DATA : HBCFG_SPI_HEADER;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			hdr_q <= 8'h00;
			load_q <= 1'b0;
		end else begin
			load_q <= hdr_last;
			if (hdr_last) begin
				hdr_q <= {rx_q[6:0], sdi_q[1]};
			end
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst || ncs_high) begin
			tx_q <= 8'h00;
			sdo_q <= 1'b0;
		end else if (load_q) begin
			tx_q <= frm.rdata;
		end else if (sclk_rise && state_q == HBCFG_SPI_DATA) begin
			sdo_q <= tx_q[7];
			tx_q <= {tx_q[6:0], 1'b0};
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			done_q <= 1'b0;
		end else begin
			done_q <= ncs_rise & (cnt_q == `HBCFG_FRAME_BITS);
		end
	end

	assign frm.frame_done = done_q;
	assign frm.is_read = hdr_q[6];
	assign frm.addr = hdr_q[5:0];
	assign frm.wdata = rx_q;
	assign frm.hdr_valid = load_q;
	assign o_sdo = sdo_q;
	assign o_sdo_oe = ~ncs_q[1];
endmodule : hbcfg_spi_shift

// ===== hw/hbcfg_top.sv
// configuration register file of the h-bridge driver with decoded settings
`timescale 1ns/10ps
`include "hbcfg_regs.svh"
module hbcfg_top
	import hbcfg_pkg::*;
#(
	parameter bit SERIAL_VARIANT = 1'b1,
	parameter logic [2:0] SLEW_CAP_CODE = 3'h3
) (
	input wire logic i_core_clk,
	input wire logic i_sys_rst,
	input wire logic i_sclk,
	input wire logic i_ncs,
	input wire logic i_sdi,
	output logic o_sdo,
	output logic o_sdo_oe,
	input wire logic i_bridge_shutoff_pin,
	input wire logic i_enable_input_one_pin,
	input wire logic i_phase_input_two_pin,
	input wire logic i_recirculating,
	input wire logic i_output_slewing,
	input wire logic i_blanking,
	output logic o_pwm_extend,
	output logic [1:0] o_load_type_select,
	output logic [2:0] o_current_trip_level_select,
	output logic [1:0] o_regulation_off_time,
	output logic [10:0] o_off_time_cycles,
	output logic [2:0] o_output_slew_select,
	output logic [2:0] o_rise_slew_select,
	output logic o_rise_slew_capped,
	output logic [1:0] o_bridge_mode,
	output logic [1:0] o_overcurrent_filter_select,
	output logic [7:0] o_filter_cycles,
	output logic [1:0] o_overcurrent_threshold_select,
	output logic [6:0] o_threshold_pct,
	output logic o_config_locked,
	output logic o_pin_reg_unlocked,
	output logic o_shutoff,
	output logic o_input_one,
	output logic o_input_two,
	output logic [1:0] o_half_bridge_off,
	output logic o_current_report_en
);
	hbcfg_frame_if frm ();

	logic [7:0] cmd_q;
	logic [7:0] cmd_d;
	logic [7:0] pin_q;
	logic [7:0] pin_d;
	logic [7:0] cfg2_q;
	logic [7:0] cfg2_d;
	logic [7:0] cfg3_q;
	logic [7:0] cfg3_d;
	logic [7:0] cfg4_q;
	logic [7:0] cfg4_d;
	logic [10:0] off_cyc_q;
	logic [7:0] filt_cyc_q;
	logic [6:0] thr_q;
	logic [2:0] rise_q;
	logic capped_q;
	logic report_q;
	logic [1:0] hb_off_q;
	logic [2:0] pin_s1_q;
	logic [2:0] pin_s2_q;
	logic [2:0] comb;

	function automatic logic [10:0] off_cycles(input logic [1:0] code);
		case (code)
			2'h0: off_cycles = 11'(`HBCFG_REGULATION_OFF_TIME_00_US * `HBCFG_CLK_MHZ);
			2'h1: off_cycles = 11'(`HBCFG_REGULATION_OFF_TIME_01_US * `HBCFG_CLK_MHZ);
			2'h2: off_cycles = 11'(`HBCFG_REGULATION_OFF_TIME_10_US * `HBCFG_CLK_MHZ);
			default: off_cycles = 11'(`HBCFG_REGULATION_OFF_TIME_11_US * `HBCFG_CLK_MHZ);
		endcase
	endfunction : off_cycles

	function automatic logic [7:0] filt_cycles(input logic [1:0] code);
		case (code)
			2'h0: filt_cycles = 8'(`HBCFG_FILT_00_NS * `HBCFG_CLK_MHZ / 1000);
			2'h1: filt_cycles = 8'(`HBCFG_FILT_01_NS * `HBCFG_CLK_MHZ / 1000);
			2'h2: filt_cycles = 8'(`HBCFG_FILT_10_NS * `HBCFG_CLK_MHZ / 1000);
			default: filt_cycles = 8'(`HBCFG_FILT_11_NS * `HBCFG_CLK_MHZ / 1000);
		endcase
	endfunction : filt_cycles

	function automatic logic [6:0] thr_pct(input logic [1:0] code);
		case (code)
			2'h0: thr_pct = `HBCFG_THR_FULL_PCT;
			2'h2: thr_pct = `HBCFG_THR_3Q_PCT;
			default: thr_pct = `HBCFG_THR_HALF_PCT;
		endcase
	endfunction : thr_pct

	function automatic hbcfg_mode_t mode_of(input logic [1:0] code);
		case (code)
			2'h1: mode_of = HBCFG_MODE_PWM;
			2'h2: mode_of = HBCFG_MODE_INDEP;
			default: mode_of = HBCFG_MODE_PH_EN;
		endcase
	endfunction : mode_of

	function automatic logic is_code(input logic [1:0] field);
		is_code = field == `HBCFG_LOCK_CODE;
	endfunction : is_code

	function automatic logic [7:0] read_back(input logic [5:0] a, input logic [7:0] cmd,
			input logic [7:0] pin, input logic [7:0] c2, input logic [7:0] c3,
			input logic [7:0] c4);
		case (a)
			`HBCFG_ADDR_CMD: read_back = cmd;
			`HBCFG_ADDR_PIN: read_back = pin;
			`HBCFG_ADDR_CFG2: read_back = c2;
			`HBCFG_ADDR_CFG3: read_back = c3;
			`HBCFG_ADDR_CFG4: read_back = c4;
			default: read_back = 8'h00;
		endcase
	endfunction : read_back

	hbcfg_spi_shift u_shift (
		.i_core_clk(i_core_clk),
		.i_sys_rst(i_sys_rst),
		.i_sclk(i_sclk),
		.i_ncs(i_ncs),
		.i_sdi(i_sdi),
		.o_sdo(o_sdo),
		.o_sdo_oe(o_sdo_oe),
		.frm(frm)
	);

	// address hits of the frame header
	wire hit_cmd = frm.addr == `HBCFG_ADDR_CMD;
	wire hit_pin = frm.addr == `HBCFG_ADDR_PIN;
	wire hit_cfg2 = frm.addr == `HBCFG_ADDR_CFG2;
	wire hit_cfg3 = frm.addr == `HBCFG_ADDR_CFG3;
	wire hit_cfg4 = frm.addr == `HBCFG_ADDR_CFG4;

	// write decode
	wire wr = frm.frame_done & ~frm.is_read;
	wire cfg_locked = is_code(cmd_q[`HBCFG_CMD_REGLOCK_LO +: 2]);
	wire pin_unlocked = is_code(cmd_q[`HBCFG_CMD_PINLOCK_LO +: 2]);
	wire wr_cmd = wr & hit_cmd;
	wire wr_pin = wr & hit_pin;
	wire wr_cfg_ok = wr & ~cfg_locked;
	wire wr_cfg2 = wr_cfg_ok & hit_cfg2;
	wire wr_cfg3 = wr_cfg_ok & hit_cfg3;
	wire wr_cfg4 = wr_cfg_ok & hit_cfg4;

	assign cmd_d = wr_cmd ? (frm.wdata & `HBCFG_MASK_CMD) : cmd_q;
	assign pin_d = wr_pin ? (frm.wdata & `HBCFG_MASK_PIN) : pin_q;
	assign cfg2_d = wr_cfg2 ? (frm.wdata & `HBCFG_MASK_CFG2) : cfg2_q;
	assign cfg3_d = wr_cfg3 ? (frm.wdata & `HBCFG_MASK_CFG3) : cfg3_q;
	assign cfg4_d = wr_cfg4 ? (frm.wdata & `HBCFG_MASK_CFG4) : cfg4_q;

	assign frm.rdata = read_back(frm.addr, cmd_q, pin_q, cfg2_q, cfg3_q, cfg4_q);

	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			cmd_q <= `HBCFG_RST_CMD;
			pin_q <= `HBCFG_RST_PIN;
		end else begin
			cmd_q <= cmd_d;
			pin_q <= pin_d;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			cfg2_q <= `HBCFG_RST_CFG2;
			cfg3_q <= `HBCFG_RST_CFG3;
			cfg4_q <= `HBCFG_RST_CFG4;
		end else begin
			cfg2_q <= cfg2_d;
			cfg3_q <= cfg3_d;
			cfg4_q <= cfg4_d;
		end
	end

	// fields of the stored registers
	wire ext_f = cfg2_q[`HBCFG_C2_EXTEND];
	wire [1:0] load_f = cfg2_q[`HBCFG_C2_LOAD_LO +: 2];
	wire [2:0] trip_f = cfg2_q[`HBCFG_C2_TRIP_LO +: 3];
	wire [1:0] regulation_off_time_f = cfg3_q[`HBCFG_C3_REGULATION_OFF_TIME_LO +: 2];
	wire [2:0] slew_f = cfg3_q[`HBCFG_C3_SLEW_LO +: 3];
	wire [1:0] mode_f = cfg3_q[`HBCFG_C3_MODE_LO +: 2];
	wire [1:0] filt_f = cfg4_q[`HBCFG_C4_FILT_LO +: 2];
	wire [1:0] thr_f = cfg4_q[`HBCFG_C4_THR_LO +: 2];

	// decoded settings from the next value and, for indep_q and low_side_q, the stored value
	wire [1:0] load_d = cfg2_d[`HBCFG_C2_LOAD_LO +: 2];
	wire [2:0] slew_d = cfg3_d[`HBCFG_C3_SLEW_LO +: 3];
	wire indep_d = mode_of(cfg3_d[`HBCFG_C3_MODE_LO +: 2]) == HBCFG_MODE_INDEP;
	wire low_side_d = indep_d & (load_d == `HBCFG_LOAD_LOW_SIDE);
	wire indep_q = mode_of(cfg3_q[`HBCFG_C3_MODE_LO +: 2]) == HBCFG_MODE_INDEP;
	wire low_side_q = indep_q & (cfg2_q[`HBCFG_C2_LOAD_LO +: 2] == `HBCFG_LOAD_LOW_SIDE);
	wire cap_d = low_side_d & (slew_d > SLEW_CAP_CODE);
	// no current report in independent low-side mode while recirculating, slewing or blanking
	wire report_d = ~(low_side_q & (i_recirculating | i_output_slewing | i_blanking));
	wire hb2_reg = pin_unlocked ? pin_q[`HBCFG_PIN_SHUTOFF2] : comb[2];
	// per-half coast only in serial variant
	wire [1:0] hb_off_d = (indep_q && SERIAL_VARIANT) ? {hb2_reg, comb[2]} : {comb[2], comb[2]};

	// off time in cycles, tracks the write edge
	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			off_cyc_q <= off_cycles(2'(`HBCFG_RST_CFG3 >> `HBCFG_C3_REGULATION_OFF_TIME_LO));
		end else begin
			off_cyc_q <= off_cycles(cfg3_d[`HBCFG_C3_REGULATION_OFF_TIME_LO +: 2]);
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			filt_cyc_q <= filt_cycles(2'(`HBCFG_RST_CFG4 >> `HBCFG_C4_FILT_LO));
		end else begin
			filt_cyc_q <= filt_cycles(cfg4_d[`HBCFG_C4_FILT_LO +: 2]);
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			thr_q <= thr_pct(2'(`HBCFG_RST_CFG4 >> `HBCFG_C4_THR_LO));
		end else begin
			thr_q <= thr_pct(cfg4_d[`HBCFG_C4_THR_LO +: 2]);
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			rise_q <= 3'h0;
			capped_q <= 1'b0;
		end else begin
			rise_q <= cap_d ? SLEW_CAP_CODE : slew_d;
			capped_q <= cap_d;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			report_q <= 1'b1;
		end else begin
			report_q <= report_d;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			hb_off_q <= 2'h0;
		end else begin
			hb_off_q <= hb_off_d;
		end
	end

	// two-stage synchronisers for pins
	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			pin_s1_q <= 3'h0;
			pin_s2_q <= 3'h0;
		end else begin
			pin_s1_q <= {i_bridge_shutoff_pin, i_enable_input_one_pin, i_phase_input_two_pin};
			pin_s2_q <= pin_s1_q;
		end
	end

	// register bits combine with pins
	hbcfg_pin_combine u_comb (
		.i_core_clk(i_core_clk),
		.i_sys_rst(i_sys_rst),
		.i_pin(pin_s2_q),
		.i_reg_bit({pin_q[`HBCFG_PIN_SHUTOFF], pin_q[`HBCFG_PIN_IN1], pin_q[`HBCFG_PIN_IN2]}),
		.i_and_sel({cfg4_q[`HBCFG_C4_SEL_SHUTOFF], cfg4_q[`HBCFG_C4_SEL_IN1],
			cfg4_q[`HBCFG_C4_SEL_IN2]}),
		.i_unlocked(pin_unlocked),
		.o_comb(comb)
	);

	assign o_pwm_extend = ext_f;
	assign o_load_type_select = load_f;
	assign o_current_trip_level_select = trip_f;
	assign o_regulation_off_time = regulation_off_time_f;
	assign o_off_time_cycles = off_cyc_q;
	assign o_output_slew_select = slew_f;
	assign o_rise_slew_select = rise_q;
	assign o_rise_slew_capped = capped_q;
	assign o_bridge_mode = mode_f;
	assign o_overcurrent_filter_select = filt_f;
	assign o_filter_cycles = filt_cyc_q;
	assign o_overcurrent_threshold_select = thr_f;
	assign o_threshold_pct = thr_q;
	assign o_config_locked = cfg_locked;
	assign o_pin_reg_unlocked = pin_unlocked;
	assign o_shutoff = comb[2];
	assign o_input_one = comb[1];
	assign o_input_two = comb[0];
	assign o_half_bridge_off = hb_off_q;
	assign o_current_report_en = report_q;
endmodule : hbcfg_top
